// ===== src/amc_pkg.sv
// Package for the converter mode and calibration control block.
// Assumes an 8-bit special-function register port on the core clock.
package amc_pkg;
  localparam logic [7:0] PRI_CFG_ADDR = 8'hD2;
  localparam logic [7:0] PRI_CFG_RESET = 8'h07;
  // Offsets below have no printed value; chosen for this block
  localparam logic [7:0] MODE_ADDR = 8'hD1;
  localparam logic [7:0] PRI_CTRL_ADDR = 8'hD3;
  localparam logic [7:0] AUX_CTRL_ADDR = 8'hD4;
  localparam logic [7:0] STATUS_ADDR = 8'hD8;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int MODE_LSB = 0;
  localparam int PRI_EN_BIT = 7;
  localparam int AUX_EN_BIT = 7;
  localparam int CHOP_OFF_BIT = 3;
  localparam logic [7:0] CFG_WMASK = 8'hE7;
  localparam int CAL_PERIODS_CHOP = 2;
  localparam int CAL_PERIODS_NOCHOP = 4;
  localparam int ALIGN_MAX_OUTPUTS = 3;
  localparam logic [1:0] BUF_BOTH = 2'b00;
  localparam logic [1:0] BUF_BYPASS = 2'b10;
  localparam logic [23:0] ZERO_UNIPOLAR = 24'h000000;
  localparam logic [23:0] ZERO_BIPOLAR = 24'h800000;

  typedef enum logic [2:0] {
    MD_PDOWN = 3'h0, MD_IDLE = 3'h1, MD_SINGLE = 3'h2, MD_CONT = 3'h3,
    MD_IZERO = 3'h4, MD_IFULL = 3'h5, MD_SZERO = 3'h6, MD_SFULL = 3'h7
  } amc_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_RUN = 4'b0010, ST_CAL = 4'b0100, ST_HOLD = 4'b1000
  } amc_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amc_sfr_t;

  typedef struct packed {
    logic bufBypass;
    logic unipolar;
    logic [2:0] rangeSel;
    logic [23:0] zeroCode;
  } amc_anacfg_t;
endpackage

// ===== src/amc_mode_cal_ctrl.sv
// Mode decode, reset sequencing and calibration control for an ADC pair.
// Assumes one-cycle SFR strobes and an analog core giving output strobes.
`timescale 1ns/1ps
`default_nettype none
module amc_mode_cal_ctrl
  import amc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire amc_sfr_t sfrReq,
  output logic [7:0] sfrRdata,
  input wire logic corePowerDown,
  input wire logic priOutStrobe,
  input wire logic auxOutStrobe,
  input wire logic [23:0] priResult,
  input wire logic [23:0] auxResult,
  input wire logic auxTempSel,
  output logic priReset,
  output logic auxReset,
  output logic priRun,
  output logic auxRun,
  output logic modHold,
  output logic inputShort,
  output logic refToInput,
  output amc_anacfg_t anaCfg,
  output logic [23:0] priOffset,
  output logic [23:0] priGain,
  output logic [23:0] auxOffset,
  output logic [23:0] auxGain,
  output logic [23:0] priData,
  output logic [23:0] auxData,
  output logic priReady,
  output logic auxReady,
  output logic auxError
);
  logic [7:0] modeReg_q, modeReg_d;
  logic [7:0] priCfg_q;
  logic [7:0] priCtrl_q;
  logic [7:0] auxCtrl_q;
  amc_state_t state_q, state_d;
  logic [2:0] calCnt_q;
  logic [1:0] alignCnt_q;
  logic auxAlign_q;
  logic priReady_q, auxReady_q, auxError_q;
  logic priReset_q, auxReset_q, priRun_q, auxRun_q, modHold_q;
  logic inputShort_q, refToInput_q;
  logic [23:0] priOffset_q, priGain_q, auxOffset_q, auxGain_q;
  logic [23:0] priData_q, auxData_q;
  logic [7:0] sfrRdata_q;
  amc_anacfg_t anaCfg_q;

  function automatic logic hit(input amc_sfr_t r, input logic [7:0] a);
    hit = r.valid && r.write && (r.addr == a);
  endfunction

  // Configuration field decode
  function automatic amc_anacfg_t cfg_decode(input logic [7:0] c);
    cfg_decode.bufBypass = (c[7:6] == BUF_BYPASS);
    cfg_decode.unipolar = c[5];
    cfg_decode.rangeSel = c[2:0];
    cfg_decode.zeroCode = c[5] ? ZERO_UNIPOLAR : ZERO_BIPOLAR;
  endfunction

  wire logic modeWr = hit(sfrReq, MODE_ADDR);
  wire logic cfgWr = hit(sfrReq, PRI_CFG_ADDR);
  wire logic priCtrlWr = hit(sfrReq, PRI_CTRL_ADDR);
  wire logic auxCtrlWr = hit(sfrReq, AUX_CTRL_ADDR);
  wire amc_mode_t mode = amc_mode_t'(modeReg_q[MODE_LSB +: 3]);
  wire amc_mode_t newMode = amc_mode_t'(sfrReq.wdata[MODE_LSB +: 3]);
  wire logic priEn = priCtrl_q[PRI_EN_BIT];
  wire logic auxEn = auxCtrl_q[AUX_EN_BIT];
  wire logic priEnRise = priCtrlWr && !priEn && sfrReq.wdata[PRI_EN_BIT];
  wire logic priHit = priCtrlWr && (priEn || priEnRise);
  wire logic bothReset = modeWr || priHit;
  wire logic auxOnlyReset = auxCtrlWr && !bothReset;
  wire logic isCal = mode[2];
  wire logic isZeroCal = isCal && !mode[0];
  wire logic chopOff = modeReg_q[CHOP_OFF_BIT];
  wire logic [2:0] calLen = chopOff ? 3'(CAL_PERIODS_NOCHOP)
                                    : 3'(CAL_PERIODS_CHOP);
  wire logic priActive = (state_q == ST_RUN) || (state_q == ST_CAL);
  wire logic calDone = (state_q == ST_CAL) && priOutStrobe
                       && (calCnt_q == calLen - 3'h1);
  wire logic auxOk = !auxTempSel;
  wire logic singleDone = (state_q == ST_RUN) && (mode == MD_SINGLE)
                          && priOutStrobe;
  wire logic auxStrobeOk = auxOutStrobe && !auxAlign_q;
  wire logic [7:0] statusVal = {priReady_q, auxReady_q, 5'h00, auxError_q};
  wire logic [7:0] rdMux =
    (sfrReq.addr == MODE_ADDR) ? modeReg_q :
    (sfrReq.addr == PRI_CFG_ADDR) ? priCfg_q :
    (sfrReq.addr == PRI_CTRL_ADDR) ? priCtrl_q :
    (sfrReq.addr == AUX_CTRL_ADDR) ? auxCtrl_q :
    (sfrReq.addr == STATUS_ADDR) ? statusVal : 8'h00;

  // Mode register next value
  always_comb
  begin
    modeReg_d = modeReg_q;
    if (modeWr)
      modeReg_d = sfrReq.wdata;
    else if (calDone || singleDone)
      modeReg_d = {modeReg_q[7:3], MD_PDOWN};
  end

  // Sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (corePowerDown)
          state_d = ST_HOLD;
        else if (bothReset)
          state_d = ST_IDLE;
        else if (isCal)
          state_d = ST_CAL;
        else if (mode == MD_SINGLE || mode == MD_CONT)
          state_d = ST_RUN;
      ST_RUN:
        if (corePowerDown)
          state_d = ST_HOLD;
        else if (bothReset || singleDone)
          state_d = ST_IDLE;
      ST_CAL:
        if (corePowerDown)
          state_d = ST_HOLD;
        else if (bothReset || calDone)
          state_d = ST_IDLE;
      ST_HOLD:
        if (!corePowerDown)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      modeReg_q <= MODE_RESET;
      state_q <= ST_IDLE;
    end
    else
    begin
      modeReg_q <= modeReg_d;
      state_q <= state_d;
    end
  end

  // Configuration and control registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      priCfg_q <= PRI_CFG_RESET;
      priCtrl_q <= CTRL_RESET;
      auxCtrl_q <= CTRL_RESET;
    end
    else
    begin
      if (cfgWr)
        priCfg_q <= sfrReq.wdata & CFG_WMASK;
      if (priCtrlWr)
        priCtrl_q <= sfrReq.wdata;
      if (auxCtrlWr)
        auxCtrl_q <= sfrReq.wdata;
    end
  end

  // Calibration period count and auxiliary alignment
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      calCnt_q <= 3'h0;
      auxAlign_q <= 1'b0;
      alignCnt_q <= 2'h0;
    end
    else
    begin
      if (state_q != ST_CAL || bothReset)
        calCnt_q <= 3'h0;
      else if (priOutStrobe)
        calCnt_q <= calCnt_q + 3'h1;
      if (bothReset || !priActive)
      begin
        auxAlign_q <= 1'b0;
        alignCnt_q <= 2'h0;
      end
      else if (auxOnlyReset || (auxCtrlWr && !auxEn))
      begin
        auxAlign_q <= 1'b1;
        alignCnt_q <= 2'h0;
      end
      else if (auxAlign_q && priOutStrobe)
      begin
        alignCnt_q <= alignCnt_q + 2'h1;
        if (alignCnt_q == 2'(ALIGN_MAX_OUTPUTS - 1))
          auxAlign_q <= 1'b0;
      end
    end
  end

  // Status flags; a completion event wins over a clearing write
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      priReady_q <= 1'b0;
      auxReady_q <= 1'b0;
      auxError_q <= 1'b0;
    end
    else
    begin
      if (calDone || singleDone || (mode == MD_CONT && priOutStrobe
          && state_q == ST_RUN))
        priReady_q <= 1'b1;
      else if (modeWr && newMode[2])
        priReady_q <= 1'b0;
      if (auxEn && (calDone || (state_q == ST_RUN && auxStrobeOk)))
        auxReady_q <= 1'b1;
      else if (modeWr && newMode[2] && auxEn)
        auxReady_q <= 1'b0;
      if (auxEn && calDone)
        auxError_q <= !auxOk;
      else if (modeWr && newMode[2] && auxEn)
        auxError_q <= 1'b0;
    end
  end

  // Coefficients and data
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      priOffset_q <= 24'h000000;
      priGain_q <= 24'h000000;
      auxOffset_q <= 24'h000000;
      auxGain_q <= 24'h000000;
      priData_q <= 24'h000000;
      auxData_q <= 24'h000000;
    end
    else
    begin
      if (calDone && priEn && isZeroCal)
        priOffset_q <= priResult;
      if (calDone && priEn && !isZeroCal)
        priGain_q <= priResult;
      if (calDone && auxEn && auxOk && isZeroCal)
        auxOffset_q <= auxResult;
      if (calDone && auxEn && auxOk && !isZeroCal)
        auxGain_q <= auxResult;
      if (state_q == ST_RUN && priOutStrobe)
        priData_q <= priResult;
      if (state_q == ST_RUN && auxEn && auxStrobeOk)
        auxData_q <= auxResult;
    end
  end

  // Converter controls
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      priReset_q <= 1'b1;
      auxReset_q <= 1'b1;
      priRun_q <= 1'b0;
      auxRun_q <= 1'b0;
      modHold_q <= 1'b0;
      inputShort_q <= 1'b0;
      refToInput_q <= 1'b0;
      sfrRdata_q <= 8'h00;
    end
    else
    begin
      priReset_q <= bothReset || mode == MD_IDLE;
      auxReset_q <= bothReset || auxOnlyReset || auxAlign_q;
      priRun_q <= priActive && priEn;
      auxRun_q <= priActive && auxEn;
      modHold_q <= (mode == MD_IDLE);
      inputShort_q <= (state_q == ST_CAL) && mode == MD_IZERO;
      refToInput_q <= (state_q == ST_CAL) && mode == MD_IFULL;
      sfrRdata_q <= rdMux;
    end
  end

  // Analog configuration held in flops for the port
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      anaCfg_q <= cfg_decode(PRI_CFG_RESET);
    else
      anaCfg_q <= cfg_decode(priCfg_q);
  end

  // System calibrations leave inputs on the selected channel
  assign priReset = priReset_q;
  assign auxReset = auxReset_q;
  assign priRun = priRun_q;
  assign auxRun = auxRun_q;
  assign modHold = modHold_q;
  assign inputShort = inputShort_q;
  assign refToInput = refToInput_q;
  assign anaCfg = anaCfg_q;
  assign priOffset = priOffset_q;
  assign priGain = priGain_q;
  assign auxOffset = auxOffset_q;
  assign auxGain = auxGain_q;
  assign priData = priData_q;
  assign auxData = auxData_q;
  assign priReady = priReady_q;
  assign auxReady = auxReady_q;
  assign auxError = auxError_q;
  assign sfrRdata = sfrRdata_q;
endmodule
`default_nettype wire

// ===== bench/amc_mode_cal_ctrl_assertions.sv
// Port checks for the mode and calibration control block.
// Assumes one clock domain, bound onto amc_mode_cal_ctrl.
`timescale 1ns/1ps
`default_nettype none
module amc_mode_cal_ctrl_assertions
  import amc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire amc_sfr_t sfrReq,
  input wire logic [7:0] sfrRdata,
  input wire logic priReset,
  input wire logic auxReset,
  input wire logic inputShort,
  input wire logic refToInput,
  input wire amc_anacfg_t anaCfg,
  input wire logic [23:0] priOffset,
  input wire logic [23:0] auxOffset,
  input wire logic [23:0] auxGain,
  input wire logic priReady,
  input wire logic auxReady,
  input wire logic auxError
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire wrEn = sfrReq.valid && sfrReq.write;
  wire [7:0] ad = sfrReq.addr;
  property p_modeRst;
    wrEn && ad == MODE_ADDR |=> priReset && auxReset;
  endproperty
  property p_priRst;
    wrEn && ad == PRI_CTRL_ADDR && sfrReq.wdata[PRI_EN_BIT]
      |=> priReset && auxReset;
  endproperty
  property p_auxRst;
    wrEn && ad == AUX_CTRL_ADDR && sfrReq.wdata[AUX_EN_BIT] && !priReset
      |=> auxReset && !priReset;
  endproperty
  property p_cfgMask;
    ad == PRI_CFG_ADDR |=> sfrRdata[4:3] == 2'b00;
  endproperty
  property p_cfgDec;
    ad == PRI_CFG_ADDR && !wrEn |=> sfrRdata[7] == anaCfg.bufBypass
      && sfrRdata[5] == anaCfg.unipolar && sfrRdata[2:0] == anaCfg.rangeSel;
  endproperty
  property p_zero;
    ad == PRI_CFG_ADDR && !wrEn |=> anaCfg.zeroCode
      == (sfrRdata[5] ? ZERO_UNIPOLAR : ZERO_BIPOLAR);
  endproperty
  property p_excl;
    !(inputShort && refToInput);
  endproperty
  property p_coef;
    !$stable(priOffset) |-> priReady;
  endproperty
  property p_auxErr;
    $rose(auxError) |-> auxReady && $stable(auxOffset) && $stable(auxGain);
  endproperty
  a_modeRst: assert property (p_modeRst) else $error("mode write no reset");
  a_priRst: assert property (p_priRst) else $error("pri write no reset");
  a_auxRst: assert property (p_auxRst) else $error("aux reset wrong");
  a_cfgMask: assert property (p_cfgMask) else $error("bits 4,3 set");
  a_cfgDec: assert property (p_cfgDec) else $error("cfg decode");
  a_zero: assert property (p_zero) else $error("zero code");
  a_excl: assert property (p_excl) else $error("short with ref");
  a_coef: assert property (p_coef) else $error("coef no ready");
  a_auxErr: assert property (p_auxErr) else $error("aux error");
  c_cal: cover property (inputShort);
  c_err: cover property ($rose(auxError));
  c_mode: cover property (wrEn && ad == MODE_ADDR);
endmodule
bind amc_mode_cal_ctrl amc_mode_cal_ctrl_assertions u_chk (.mclk(mclk),
  .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
  .priReset(priReset), .auxReset(auxReset), .inputShort(inputShort),
  .refToInput(refToInput), .anaCfg(anaCfg), .priOffset(priOffset),
  .auxOffset(auxOffset), .auxGain(auxGain), .priReady(priReady),
  .auxReady(auxReady), .auxError(auxError));
`default_nettype wire

// ===== bench/amc_mode_cal_ctrl_tb.sv
// Self-checking bench for the mode and calibration control block.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`default_nettype none
module amc_mode_cal_ctrl_tb import amc_pkg::*;;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  amc_sfr_t sfrReq = '0;
  logic pwrDn = 1'b0, priStb = 1'b0, auxStb = 1'b0, tempSel = 1'b0;
  logic [23:0] res = '0;
  logic [7:0] rdat;
  logic priReset, auxReset, priRun, auxRun, modHold, inShort, refIn;
  amc_anacfg_t anaCfg;
  logic [23:0] priOff, priGain, auxOff, auxGain, priData, auxData;
  logic priRdy, auxRdy, auxErr;
  int n_errors = 0;
  int n_checks = 0;
  logic [15:0] rows [4] = '{16'hBFA7, 16'h9880, 16'h2525, 16'h0303};
  logic [23:0] cv;
  always #5 mclk = ~mclk;
  amc_mode_cal_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .sfrReq(sfrReq),
    .sfrRdata(rdat), .corePowerDown(pwrDn), .priOutStrobe(priStb),
    .auxOutStrobe(auxStb), .priResult(res), .auxResult(res),
    .auxTempSel(tempSel), .priReset(priReset), .auxReset(auxReset),
    .priRun(priRun), .auxRun(auxRun), .modHold(modHold),
    .inputShort(inShort), .refToInput(refIn), .anaCfg(anaCfg),
    .priOffset(priOff), .priGain(priGain), .auxOffset(auxOff),
    .auxGain(auxGain), .priData(priData), .auxData(auxData),
    .priReady(priRdy), .auxReady(auxRdy), .auxError(auxErr));
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrReq <= '{1'b1, 1'b1, a, d};
    @(posedge mclk);
    sfrReq.valid <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    sfrReq <= '{1'b0, 1'b0, a, 8'h00};
    repeat (2) @(posedge mclk);
    #1 chk({16'h0, rdat}, {16'h0, e});
  endtask
  task automatic strb(input int n, input logic [23:0] v);
    repeat (n)
    begin
      @(posedge mclk);
      priStb <= 1'b1;
      auxStb <= 1'b1;
      res <= v;
      @(posedge mclk);
      priStb <= 1'b0;
      auxStb <= 1'b0;
    end
    repeat (3) @(posedge mclk);
  endtask
  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(PRI_CFG_ADDR, PRI_CFG_RESET);
    rd(MODE_ADDR, 8'h00);
    rd(8'h00, 8'h00);
    foreach (rows[i])
    begin
      wr(PRI_CFG_ADDR, rows[i][15:8]);
      rd(PRI_CFG_ADDR, rows[i][7:0]);
      chk(anaCfg.zeroCode, rows[i][13] ? 24'h0 : 24'h800000);
      chk({21'h0, anaCfg.rangeSel}, {21'h0, rows[i][2:0]});
      chk({23'h0, anaCfg.bufBypass}, {23'h0, rows[i][15]});
    end
    wr(PRI_CTRL_ADDR, 8'h80);
    for (int c = 4; c < 8; c++)
    begin
      cv = {c[3:0], 20'h5A5A5};
      wr(MODE_ADDR, c[7:0]);
      repeat (2) @(posedge mclk);
      #1 chk({22'h0, inShort, refIn}, {22'h0, c == 4, c == 5});
      chk({23'h0, priRdy}, 24'h0);
      strb(1, cv);
      rd(MODE_ADDR, c[7:0]);
      strb(1, cv);
      rd(MODE_ADDR, 8'h00);
      chk(c[0] ? priGain : priOff, cv);
      chk({23'h0, priRdy}, 24'h1);
    end
    wr(MODE_ADDR, 8'h0C);
    strb(2, 24'h00F00D);
    chk(priOff, 24'h65A5A5);
    strb(2, 24'h00F00D);
    chk(priOff, 24'h00F00D);
    wr(MODE_ADDR, 8'h03);
    pwrDn <= 1'b1;
    repeat (4) @(posedge mclk);
    pwrDn <= 1'b0;
    rd(MODE_ADDR, 8'h03);
    chk({23'h0, priRun}, 24'h1);
    chk({23'h0, auxRun}, 24'h0);
    strb(1, 24'h123456);
    tempSel <= 1'b1;
    chk(priData, 24'h123456);
    wr(AUX_CTRL_ADDR, 8'h80);
    strb(ALIGN_MAX_OUTPUTS, 24'h0000AA);
    chk(auxData, 24'h000000);
    strb(1, 24'h0000BB);
    chk(auxData, 24'h0000BB);
    chk({22'h0, priRun, auxRun}, 24'h3);
    wr(MODE_ADDR, 8'h04);
    strb(2, 24'h0BAD00);
    chk({22'h0, auxRdy, auxErr}, 24'h3);
    chk(auxOff, 24'h0);
    rd(STATUS_ADDR, 8'hC1);
    wr(MODE_ADDR, 8'h02);
    strb(1, 24'h0000CC);
    rd(MODE_ADDR, 8'h00);
    chk(priData, 24'h0000CC);
    wr(MODE_ADDR, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk({22'h0, modHold, priReset}, 24'h3);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(MODE_ADDR, 8'h00);
    rd(PRI_CFG_ADDR, PRI_CFG_RESET);
    chk({22'h0, priRdy, auxRdy}, 24'h0);
    stop_test();
  end
endmodule
`default_nettype wire
